/* nvpp_defines.vh */
// Constants of the programming port: commands, timing, reset values.
// Assumes inclusion by bare name from the design file only.
`ifndef NVPP_DEFINES_VH
`define NVPP_DEFINES_VH

`define NVPP_CLK_MHZ      125
// Parallel commands
`define NVPP_CMD_ERASE    8'h80
`define NVPP_CMD_WR_FUSE  8'h40
`define NVPP_CMD_WR_LOCK  8'h20
`define NVPP_CMD_WR_FLASH 8'h10
`define NVPP_CMD_WR_EE    8'h11
`define NVPP_CMD_RD_SIG   8'h08
`define NVPP_CMD_RD_FUSE  8'h04
`define NVPP_CMD_RD_FLASH 8'h02
`define NVPP_CMD_RD_EE    8'h03
// Action select codes
`define NVPP_ACT_ADDR     2'b00
`define NVPP_ACT_DATA     2'b01
`define NVPP_ACT_CMD      2'b10
// Serial instruction bytes; chip erase is a 3-bit field
`define NVPP_SER_PFX      8'hac
`define NVPP_SER_PE       8'h53
`define NVPP_SER_CE       3'b100
`define NVPP_SER_WR_EE    8'hc0
// Self-timed write windows, microseconds
`define NVPP_T_MEM_MIN_US 1000
`define NVPP_T_MEM_TYP_US 1500
`define NVPP_T_MEM_MAX_US 1900
`define NVPP_T_CE_MIN_US  16000
`define NVPP_T_CE_TYP_US  23000
`define NVPP_T_CE_MAX_US  30000
`define NVPP_T_PG_MIN_US  8000
`define NVPP_T_PG_TYP_US  12000
`define NVPP_T_PG_MAX_US  15000
// Field positions and reserved-bit masks
`define NVPP_FL_SERIAL_PROG_ENABLE_FUSE     5
`define NVPP_FUSE_LO_RSV  8'h10
`define NVPP_FUSE_HI_RSV  8'hf8
`define NVPP_LOCK_RSV     8'hc0
// Reset values, erased values and last flash address
`define NVPP_FUSE_LO_RST  8'hdf
`define NVPP_FUSE_HI_RST  8'hff
`define NVPP_LOCK_RST     8'hff
`define NVPP_FLASH_LAST   13'h1fff
`define NVPP_ERASED_W     16'hffff
`define NVPP_ERASED_B     8'hff

`endif

/* nvpp_port.v */
// Programming port logic: parallel byte port, serial download, memories.
// Assumes all pins are asynchronous to mclk and strobes last several cycles.
`timescale 1ns/100ps
`default_nettype none
`include "nvpp_defines.vh"

module nvpp_port #(
    parameter [23:0] T_MEM_CYC = `NVPP_T_MEM_TYP_US * `NVPP_CLK_MHZ,
    parameter [23:0] T_CE_CYC  = `NVPP_T_CE_TYP_US * `NVPP_CLK_MHZ,
    parameter [23:0] T_PG_CYC  = `NVPP_T_PG_TYP_US * `NVPP_CLK_MHZ,
    // Identity values are arbitrary
    parameter [7:0]  SIG_B0    = 8'h5a,
    parameter [7:0]  SIG_B1    = 8'h01,
    parameter [7:0]  SIG_B2    = 8'h02,
    parameter [7:0]  CAL_BYTE  = 8'h80
) (
    input  wire       mclk,
    input  wire       nrst,
    input  wire       crystal_strobe,
    input  wire       action_select_hi,
    input  wire       action_select_lo,
    input  wire       byte_select_one,
    input  wire       byte_select_two,
    input  wire       out_enable_n,
    input  wire       write_strobe_n,
    input  wire       page_latch_strobe,
    input  wire       prog_reset_n,
    input  wire       sck,
    input  wire       mosi,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out_q,
    output reg        data_oe_q,
    output reg        ready_busy_n,
    output reg        miso_q
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BUSY = 2'b10;

    reg  [18:0] sync1_q;
    reg  [18:0] sync2_q;
    reg  [18:0] prev_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  addr_lo_q;
    reg  [7:0]  addr_hi_q;
    reg  [7:0]  data_q;
    reg  [15:0] word_q;
    reg  [7:0]  fuse_lo_q;
    reg  [7:0]  fuse_hi_q;
    reg  [7:0]  lock_q;
    reg  [1:0]  st_q;
    reg  [23:0] tmr_q;
    reg         erase_q;
    reg  [12:0] ecnt_q;
    reg  [31:0] sh_q;
    reg  [4:0]  bcnt_q;
    reg         sdone_q;
    reg         pen_q;
    reg  [7:0]  rd_mux;
    reg  [15:0] flash_mem [0:8191];
    reg  [7:0]  ee_mem [0:511];

    wire [7:0]  d_s     = sync2_q[7:0];
    wire        bs1_s   = sync2_q[15];
    wire        bs2_s   = sync2_q[14];
    wire        oe_n_s  = sync2_q[13];
    wire        prst_s  = sync2_q[10];
    wire        xt_rise = sync2_q[18] & ~prev_q[18];
    wire        wr_fall = ~sync2_q[12] & prev_q[12];
    wire        pl_rise = sync2_q[11] & ~prev_q[11];
    wire        sk_rise = sync2_q[9] & ~prev_q[9];
    wire        sk_fall = ~sync2_q[9] & prev_q[9];
    wire        idle    = st_q[0];
    wire [12:0] fl_addr = {addr_hi_q[4:0], addr_lo_q};
    wire [8:0]  ee_addr = {addr_hi_q[0], addr_lo_q};
    wire [8:0]  se_addr = {sh_q[16], sh_q[15:8]};

    wire par_wr  = wr_fall & idle & prst_s;
    wire pw_ce   = par_wr & (cmd_q == `NVPP_CMD_ERASE);
    wire pw_fuse = par_wr & (cmd_q == `NVPP_CMD_WR_FUSE);
    wire pw_lock = par_wr & (cmd_q == `NVPP_CMD_WR_LOCK) & ~bs1_s;
    wire pw_fl   = par_wr & (cmd_q == `NVPP_CMD_WR_FLASH);
    wire pw_ee   = par_wr & (cmd_q == `NVPP_CMD_WR_EE) & ~bs1_s;
    wire ser_pfx = sdone_q & (sh_q[31:24] == `NVPP_SER_PFX);
    wire sw_pe   = ser_pfx & (sh_q[23:16] == `NVPP_SER_PE) & ~fuse_lo_q[`NVPP_FL_SERIAL_PROG_ENABLE_FUSE];
    wire sw_ce   = ser_pfx & (sh_q[23:21] == `NVPP_SER_CE) & pen_q & idle;
    wire sw_ee   = sdone_q & (sh_q[31:24] == `NVPP_SER_WR_EE) & pen_q & idle;
    wire go_ce   = pw_ce | sw_ce;
    wire go_any  = go_ce | pw_fuse | pw_lock | pw_fl | pw_ee | sw_ee;

    // Pins cross into mclk through two stages before any use
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 19'h00000;
            sync2_q <= 19'h00000;
            prev_q  <= 19'h00000;
        end else begin
            sync1_q <= {crystal_strobe, action_select_hi, action_select_lo, byte_select_one,
                        byte_select_two, out_enable_n, write_strobe_n, page_latch_strobe,
                        prog_reset_n, sck, mosi, data_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Loads ignored while busy so a write never sees its operands move
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_q     <= 8'h00;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            data_q    <= 8'hff;
            word_q    <= `NVPP_ERASED_W;
        end else if (idle) begin
            if (xt_rise) begin
                case (sync2_q[17:16])
                    `NVPP_ACT_ADDR: begin
                        if (bs1_s) begin
                            addr_hi_q <= d_s;
                        end else begin
                            addr_lo_q <= d_s;
                        end
                    end
                    `NVPP_ACT_DATA: data_q <= d_s;
                    `NVPP_ACT_CMD:  cmd_q <= d_s;
                    default: ;
                endcase
            end
            if (pl_rise) begin
                if (bs1_s) begin
                    word_q[15:8] <= data_q;
                end else begin
                    word_q[7:0] <= data_q;
                end
            end
        end
    end

    // Write engine; busy starts the edge after the synchronised strobe fall
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q         <= ST_IDLE;
            tmr_q        <= 24'h000000;
            erase_q      <= 1'b0;
            ecnt_q       <= 13'h0000;
            ready_busy_n <= 1'b1;
            fuse_lo_q    <= `NVPP_FUSE_LO_RST;
            fuse_hi_q    <= `NVPP_FUSE_HI_RST;
            lock_q       <= `NVPP_LOCK_RST;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (go_any) begin
                        st_q         <= ST_BUSY;
                        ready_busy_n <= 1'b0;
                        erase_q      <= go_ce;
                        ecnt_q       <= 13'h0000;
                        if (go_ce) begin
                            tmr_q <= T_CE_CYC;
                        end else if (pw_fl) begin
                            tmr_q <= T_PG_CYC;
                        end else begin
                            tmr_q <= T_MEM_CYC;
                        end
                    end
                    if (pw_fuse & bs1_s) begin
                        fuse_hi_q <= data_q | `NVPP_FUSE_HI_RSV;
                    end
                    if (pw_fuse & ~bs1_s) begin
                        fuse_lo_q <= data_q | `NVPP_FUSE_LO_RSV;
                    end
                    if (pw_lock) begin
                        lock_q <= lock_q & (data_q | `NVPP_LOCK_RSV);
                    end
                end
                ST_BUSY: begin
                    if (tmr_q != 24'h000000) begin
                        tmr_q <= tmr_q - 24'h000001;
                    end
                    if (erase_q) begin
                        ecnt_q <= ecnt_q + 13'h0001;
                        if (ecnt_q == `NVPP_FLASH_LAST) begin
                            erase_q <= 1'b0;
                            lock_q  <= `NVPP_LOCK_RST;
                        end
                    end
                    if ((tmr_q <= 24'h000001) & ~erase_q) begin
                        st_q         <= ST_IDLE;
                        ready_busy_n <= 1'b1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Serial shifter; leaving serial mode drops the enable
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sh_q    <= 32'h00000000;
            bcnt_q  <= 5'h00;
            sdone_q <= 1'b0;
            pen_q   <= 1'b0;
            miso_q  <= 1'b0;
        end else if (prst_s) begin
            bcnt_q  <= 5'h00;
            sdone_q <= 1'b0;
            pen_q   <= 1'b0;
            miso_q  <= 1'b0;
        end else begin
            sdone_q <= sk_rise & (bcnt_q == 5'h1f);
            if (sk_rise) begin
                sh_q   <= {sh_q[30:0], sync2_q[8]};
                bcnt_q <= bcnt_q + 5'h01;
            end
            // Echoes the previous byte, so the second byte returns during the third
            if (sk_fall) begin
                miso_q <= sh_q[7];
            end
            if (sw_pe) begin
                pen_q <= 1'b1;
            end
        end
    end

    // Arrays carry no reset; erase walks them during the busy time
    always @(posedge mclk) begin
        if (erase_q) begin
            flash_mem[ecnt_q]   <= `NVPP_ERASED_W;
            ee_mem[ecnt_q[8:0]] <= `NVPP_ERASED_B;
        end
        if (pw_fl & idle) begin
            flash_mem[fl_addr] <= flash_mem[fl_addr] & word_q;
        end
        // Parallel write only programs zeros
        if (pw_ee & idle) begin
            ee_mem[ee_addr] <= ee_mem[ee_addr] & data_q;
        end
        if (sw_ee) begin
            ee_mem[se_addr] <= sh_q[7:0];
        end
    end

    always @* begin
        rd_mux = 8'hff;
        case (cmd_q)
            `NVPP_CMD_RD_FLASH: rd_mux = bs1_s ? flash_mem[fl_addr][15:8] : flash_mem[fl_addr][7:0];
            `NVPP_CMD_RD_EE:    rd_mux = ee_mem[ee_addr];
            `NVPP_CMD_RD_FUSE: begin
                case ({bs2_s, bs1_s})
                    2'b00:   rd_mux = fuse_lo_q;
                    2'b11:   rd_mux = fuse_hi_q;
                    2'b01:   rd_mux = lock_q;
                    default: rd_mux = 8'hff;
                endcase
            end
            `NVPP_CMD_RD_SIG: begin
                if (bs1_s) begin
                    rd_mux = (addr_lo_q == 8'h00) ? CAL_BYTE : 8'hff;
                end else begin
                    case (addr_lo_q)
                        8'h00:   rd_mux = SIG_B0;
                        8'h01:   rd_mux = SIG_B1;
                        8'h02:   rd_mux = SIG_B2;
                        default: rd_mux = 8'hff;
                    endcase
                end
            end
            default: rd_mux = 8'hff;
        endcase
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_out_q <= 8'h00;
            data_oe_q  <= 1'b0;
        end else begin
            data_out_q <= rd_mux;
            data_oe_q  <= ~oe_n_s & prst_s;
        end
    end

endmodule
`default_nettype wire

/* nvpp_port_sva.sv */
// Checker of the programming port pins: bus drive and busy timing.
// Assumes write strobes are pulsed only for write commands.
`timescale 1ns/100ps
`default_nettype none
module nvpp_port_sva #(
    parameter [23:0] T_MEM_CYC = 24'd20,
    parameter [23:0] T_CE_CYC  = 24'd60
) (
    input wire mclk,
    input wire nrst,
    input wire out_enable_n,
    input wire write_strobe_n,
    input wire prog_reset_n,
    input wire data_oe_q,
    input wire ready_busy_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    reg [23:0] busy_cnt_q;
    // Busy length counter, far too long for a repetition
    always @(posedge mclk or negedge nrst)
        if (!nrst)
            busy_cnt_q <= 24'h0;
        else
            busy_cnt_q <= ready_busy_n ? 24'h0 : busy_cnt_q + 24'h1;
    sequence s_read_held;
        (!out_enable_n && prog_reset_n)[*5];
    endsequence
    sequence s_wr_start;
        $fell(write_strobe_n) && ready_busy_n && prog_reset_n;
    endsequence
    AST_OE_DRIVE: assert property (s_read_held |-> data_oe_q)
        else $error("bus not driven during read");
    AST_OE_IDLE: assert property (out_enable_n[*5] |-> !data_oe_q)
        else $error("bus driven with output enable high");
    AST_RELEASE: assert property ($rose(out_enable_n) |-> ##[2:4] !data_oe_q)
        else $error("bus not released");
    AST_SERIAL_QUIET: assert property ((!prog_reset_n)[*5] |-> !data_oe_q)
        else $error("bus driven in serial mode");
    AST_BUSY_SOON: assert property (s_wr_start |-> ##[1:312] !ready_busy_n)
        else $error("busy late after write strobe");
    AST_BUSY_HELD: assert property ($fell(ready_busy_n) |-> (!ready_busy_n)[*8])
        else $error("busy pulse too short");
    AST_BUSY_MIN: assert property ($rose(ready_busy_n) |-> busy_cnt_q >= T_MEM_CYC - 24'd1)
        else $error("busy ended early");
    AST_BUSY_MAX: assert property (busy_cnt_q <= T_CE_CYC + 24'd8300)
        else $error("busy too long");
endmodule
bind nvpp_port nvpp_port_sva #(.T_MEM_CYC(T_MEM_CYC), .T_CE_CYC(T_CE_CYC)) u_sva (.mclk(mclk), .nrst(nrst),
    .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n), .prog_reset_n(prog_reset_n),
    .data_oe_q(data_oe_q), .ready_busy_n(ready_busy_n));
`default_nettype wire

/* nvpp_prog_model.sv */
// Programmer model: drives the parallel and serial pins of the port.
// Assumes callers enter its tasks just after a rising mclk edge.
`timescale 1ns/100ps
`default_nettype none
module nvpp_prog_model (
    input  wire        mclk,
    input  wire  [7:0] data_out_q,
    input  wire        data_oe_q,
    input  wire        miso_q,
    output logic       crystal_strobe,
    output logic       action_select_hi,
    output logic       action_select_lo,
    output logic       byte_select_one,
    output logic       byte_select_two,
    output logic       out_enable_n,
    output logic       write_strobe_n,
    output logic       page_latch_strobe,
    output logic       prog_reset_n,
    output logic       sck,
    output logic       mosi,
    output logic [7:0] bus_drive
);
    // Idle pins: no action, reads and writes off, parallel mode
    initial {crystal_strobe, action_select_hi, action_select_lo, byte_select_one, byte_select_two, out_enable_n,
        write_strobe_n, page_latch_strobe, prog_reset_n, sck, mosi, bus_drive} = {11'h334, 8'h00};
    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Four cycles per level: pins pass a sync chain
    task automatic load(input [1:0] act, input bs, input [7:0] d);
        {action_select_hi, action_select_lo} <= act;
        byte_select_one <= bs;
        bus_drive <= d;
        gap(4);
        crystal_strobe <= 1'b1;
        gap(4);
        crystal_strobe <= 1'b0;
        gap(4);
    endtask
    task automatic latch(input bs);
        byte_select_one <= bs;
        gap(4);
        page_latch_strobe <= 1'b1;
        gap(4);
        page_latch_strobe <= 1'b0;
        gap(4);
    endtask
    task automatic write(input bs);
        byte_select_one <= bs;
        gap(4);
        write_strobe_n <= 1'b0;
        gap(4);
        write_strobe_n <= 1'b1;
        gap(4);
    endtask
    // Released bus shows the inverse, not a stale value
    task automatic read(input b2, input b1, output [7:0] v, output drv, output rel);
        {byte_select_two, byte_select_one} <= {b2, b1};
        bus_drive <= ~bus_drive;
        gap(4);
        out_enable_n <= 1'b0;
        gap(6);
        v = data_out_q;
        drv = data_oe_q;
        out_enable_n <= 1'b1;
        gap(5);
        rel = data_oe_q;
        byte_select_two <= 1'b0;
    endtask
    task automatic set_mode(input m);
        prog_reset_n <= m;
        gap(8);
    endtask
    task automatic send(input [31:0] w, output [7:0] echo);
        for (int i = 31; i >= 0; i--) begin
            mosi <= w[i];
            gap(4);
            // Third byte brings the second one back on miso
            if (i <= 15 && i >= 8)
                echo[i - 8] = miso_q;
            sck <= 1'b1;
            gap(4);
            sck <= 1'b0;
        end
        gap(4);
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// Bench of the programming port: loads, writes, reads, serial mode.
// Assumes the programmer model drives every pin of the port except mclk and nrst; data_in comes through the bus mux.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       mclk = 1'b0;
    logic       nrst = 1'b0;
    wire  [7:0] data_in, dout, bus;
    wire        doe, rbn, xs, ah, al, b1, b2, oe, wr, pl, pr, sck, mosi, miso;
    int         fail_count = 0;
    int         n_tests = 0;
    int         n;
    logic [7:0] v;
    logic       drv, rel;
    assign data_in = doe ? dout : bus;
    initial forever #4 mclk = ~mclk;
    nvpp_port #(.T_MEM_CYC(24'd20), .T_CE_CYC(24'd60), .T_PG_CYC(24'd40)) uut (.mclk(mclk), .nrst(nrst),
        .crystal_strobe(xs), .action_select_hi(ah), .action_select_lo(al), .byte_select_one(b1),
        .byte_select_two(b2), .out_enable_n(oe), .write_strobe_n(wr), .page_latch_strobe(pl), .prog_reset_n(pr),
        .sck(sck), .mosi(mosi), .data_in(data_in), .data_out_q(dout), .data_oe_q(doe), .ready_busy_n(rbn),
        .miso_q(miso));
    nvpp_prog_model prog (.mclk(mclk), .data_out_q(dout), .data_oe_q(doe), .miso_q(miso), .crystal_strobe(xs),
        .action_select_hi(ah), .action_select_lo(al), .byte_select_one(b1), .byte_select_two(b2),
        .out_enable_n(oe), .write_strobe_n(wr), .page_latch_strobe(pl), .prog_reset_n(pr), .sck(sck),
        .mosi(mosi), .bus_drive(bus));
    task automatic chk(input [7:0] got, input [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic rd(input bb2, input bb1, input [7:0] exp);
        prog.read(bb2, bb1, v, drv, rel);
        chk(v, exp);
        chk({6'h0, drv, rel}, 8'h02);
    endtask
    // Bounded waits: a stuck busy ends the run
    task automatic bw(input int lo, input int hi);
        for (int i = 0; i < 400 && rbn; i++) @(posedge mclk);
        for (n = 0; n < 20000 && !rbn; n++) @(posedge mclk);
        if (rbn !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t busy timeout", $time);
            give_verdict;
        end
        chk({7'h0, n >= lo && n <= hi}, 8'h01);
    endtask
    task automatic ld(input [1:0] a, input bs, input [7:0] d);
        prog.load(a, bs, d);
    endtask
    // Refused serial command: busy must stay high
    task automatic quiet;
        n = 0;
        repeat (60) begin
            @(posedge mclk);
            n += !rbn;
        end
        chk(n[7:0], 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        ld(2'b10, 0, 8'h04);
        rd(0, 0, 8'hdf);
        rd(1, 1, 8'hff);
        rd(0, 1, 8'hff);
        ld(2'b10, 0, 8'h08);
        for (int a = 0; a < 3; a++) begin
            ld(2'b00, 0, a[7:0]);
            rd(0, 0, a == 0 ? 8'h5a : a[7:0]);
        end
        ld(2'b00, 0, 8'h00);
        rd(0, 1, 8'h80);
        ld(2'b10, 0, 8'h80);
        prog.write(0);
        bw(8000, 9000);
        ld(2'b10, 0, 8'h02);
        ld(2'b00, 1, 8'h1f);
        ld(2'b00, 0, 8'hff);
        rd(0, 1, 8'hff);
        ld(2'b10, 0, 8'h11);
        ld(2'b00, 1, 8'h01);
        ld(2'b00, 0, 8'h23);
        ld(2'b01, 0, 8'h3c);
        prog.write(0);
        bw(12, 24);
        ld(2'b10, 0, 8'h03);
        rd(0, 0, 8'h3c);
        ld(2'b10, 0, 8'h10);
        ld(2'b01, 0, 8'ha5);
        prog.latch(0);
        ld(2'b01, 1, 8'h5a);
        prog.latch(1);
        prog.write(0);
        bw(32, 44);
        ld(2'b10, 0, 8'h02);
        rd(0, 0, 8'ha5);
        rd(0, 1, 8'h5a);
        ld(2'b10, 0, 8'h40);
        ld(2'b01, 0, 8'h45);
        prog.write(0);
        bw(12, 24);
        ld(2'b01, 0, 8'hfa);
        prog.write(1);
        bw(12, 24);
        ld(2'b10, 0, 8'h20);
        ld(2'b01, 0, 8'hf0);
        prog.write(0);
        bw(12, 24);
        ld(2'b01, 0, 8'hfc);
        prog.write(0);
        bw(12, 24);
        ld(2'b10, 0, 8'h04);
        rd(0, 0, 8'h55);
        rd(1, 1, 8'hfa);
        rd(0, 1, 8'hf0);
        prog.set_mode(0);
        prog.send(32'hc0012399, v);
        quiet;
        prog.send(32'hac530000, v);
        chk(v, 8'h53);
        prog.send(32'hc0012399, v);
        bw(12, 24);
        prog.set_mode(1);
        ld(2'b10, 0, 8'h03);
        rd(0, 0, 8'h99);
        prog.set_mode(0);
        prog.send(32'hac800000, v);
        quiet;
        prog.send(32'hac530000, v);
        prog.send(32'hac800000, v);
        bw(8000, 9000);
        prog.set_mode(1);
        ld(2'b10, 0, 8'h03);
        rd(0, 0, 8'hff);
        ld(2'b10, 0, 8'h04);
        rd(0, 1, 8'hff);
        rd(0, 0, 8'h55);
        give_verdict;
    end
endmodule
`default_nettype wire
